// *** core/nos_buf_if.sv ***
// Interface: valid/ready stream between the sequencer and its two-entry buffer.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface nos_buf_if #(parameter int WIDTH = 8);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;
   modport buf_side (input in_valid, input in_data, output in_ready,
                     output out_valid, output out_data, input out_ready);
   modport user_side (output in_valid, output in_data, input in_ready,
                      input out_valid, input out_data, output out_ready);
endinterface // nos_buf_if

// *** core/nos_host_ctrl.sv ***
// Module: host controller driving an 8-bit NAND flash through its pins.
// Assumes the pins are wired directly; ready_busy_n has a pull-up outside.
`timescale 1ns/1ps

module nos_host_ctrl #(
   parameter int POWER_UP_CYC = nos_pkg::POWER_UP_CYCLES,
   parameter int READ_TO_CYC  = nos_pkg::READ_TIMEOUT_CYCLES,
   parameter int PROG_TO_CYC  = nos_pkg::PROGRAM_TIMEOUT_CYCLES,
   parameter int ERASE_TO_CYC = nos_pkg::ERASE_TIMEOUT_CYCLES,
   parameter int RESET_TO_CYC = nos_pkg::RESET_TIMEOUT_CYCLES,
   parameter int BYTE_CNT     = nos_pkg::PAGE_BYTES
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // User request port
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [1:0]  req_op,
   input  wire logic [27:0] req_addr,
   input  wire logic [11:0] req_len,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [7:0]  wr_data,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [7:0]       rd_data,
   output logic             done,
   output logic             fail,
   output logic             timeout,
   output logic             part_limit_err,
   output logic             powered_up,
   // NAND pins
   output logic             command_latch_strobe,
   output logic             address_latch_strobe,
   output logic             chip_select_n,
   output logic             write_strobe_n,
   output logic             output_strobe_n,
   output logic             write_guard_n,
   input  wire logic        ready_busy_n,
   input  wire logic [7:0]  io_in,
   output logic [7:0]       io_out,
   output logic             io_oe_n
);
   initial begin
      if (POWER_UP_CYC < 1 || READ_TO_CYC < 1 || PROG_TO_CYC < 1 || ERASE_TO_CYC < 1 ||
          RESET_TO_CYC < 1 || BYTE_CNT < 1 || BYTE_CNT > 4095)
         $error("nos_host_ctrl: bad timing or length parameter");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic       rb_s1_reg, rb_s2_reg;
   logic [7:0] io_s1_reg, io_s2_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rb_s1_reg <= 1'b0;
         rb_s2_reg <= 1'b0;
         io_s1_reg <= 8'h00;
         io_s2_reg <= 8'h00;
      end else begin
         rb_s1_reg <= ready_busy_n;
         rb_s2_reg <= rb_s1_reg;
         io_s1_reg <= io_in;
         io_s2_reg <= io_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read buffer
   // ----------------------------------------------------------------
   nos_buf_if #(.WIDTH(8)) rbuf ();
   nos_skid_buf #(.WIDTH(8)) u_rbuf (
      .core_clk (core_clk),
      .nrst     (nrst),
      .bus      (rbuf)
   );
   assign rd_valid       = rbuf.out_valid;
   assign rd_data        = rbuf.out_data;
   assign rbuf.out_ready = rd_ready;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_POWER = 4'h0, ST_IDLE = 4'h1, ST_CMD1 = 4'h3, ST_ADDR = 4'h2,
      ST_DATA  = 4'h6, ST_CMD2 = 4'h7, ST_WAIT = 4'h5, ST_STCMD = 4'h4,
      ST_STRD  = 4'hc, ST_RDDAT = 4'hd, ST_DONE = 4'hf
   } nos_state_t;
   // Phase of one bus cycle: 0 set up, 1 strobe low, 2 write strobe high but read strobe still low, 3 hold
   nos_state_t  st_reg, st_next;
   logic [1:0]  ph_reg, ph_next;
   logic [1:0]  op_reg, op_next;
   logic [27:0] addr_reg, addr_next;
   logic [11:0] cnt_reg, cnt_next;
   logic [11:0] len_reg, len_next;
   logic [2:0]  acnt_reg, acnt_next;
   logic [31:0] tmr_reg, tmr_next;
   logic [7:0]  dout_reg, dout_next;
   logic [2:0]  nop_reg, nop_next;
   logic [27:0] last_page_reg, last_page_next;
   logic        fail_reg, fail_next, to_reg, to_next, done_reg, done_next;
   logic        perr_reg, perr_next, wg_reg, wg_next;
   // Timeout budget for the operation in flight
   function automatic logic [31:0] op_limit(input logic [1:0] op);
      case (op)
         nos_pkg::NOS_OP_READ:  op_limit = 32'(READ_TO_CYC);
         nos_pkg::NOS_OP_PROG:  op_limit = 32'(PROG_TO_CYC);
         nos_pkg::NOS_OP_ERASE: op_limit = 32'(ERASE_TO_CYC);
         default:               op_limit = 32'(RESET_TO_CYC);
      endcase
   endfunction
   // Address byte for a given cycle; erase sends row bytes only
   function automatic logic [7:0] addr_byte(input logic [27:0] a, input logic [2:0] i,
                                            input logic row_only);
      logic [2:0] k;
      k = row_only ? i + 3'h2 : i;
      case (k)
         3'h0:    addr_byte = a[7:0];
         3'h1:    addr_byte = {4'h0, a[11:8]};
         3'h2:    addr_byte = a[19:12];
         default: addr_byte = a[27:20];
      endcase
   endfunction
   logic is_erase;
   assign is_erase  = (op_reg == nos_pkg::NOS_OP_ERASE);
   assign req_ready = (st_reg == ST_IDLE);
   assign wr_ready  = (st_reg == ST_DATA) && (ph_reg == 2'h0);
   assign rbuf.in_valid = (st_reg == ST_RDDAT) && (ph_reg == 2'h3);
   assign rbuf.in_data  = io_s2_reg;
   // Next-state logic
   always_comb begin
      st_next = st_reg; ph_next = ph_reg; op_next = op_reg; addr_next = addr_reg;
      cnt_next = cnt_reg; len_next = len_reg; acnt_next = acnt_reg;
      tmr_next = tmr_reg + 32'h1; dout_next = dout_reg; nop_next = nop_reg;
      last_page_next = last_page_reg; fail_next = fail_reg; to_next = to_reg;
      done_next = 1'b0; perr_next = perr_reg; wg_next = wg_reg;
      case (st_reg)
         ST_POWER: begin
            wg_next = (tmr_reg >= 32'(POWER_UP_CYC));
            if (wg_next) st_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (req_valid) begin
               op_next = req_op; addr_next = req_addr; len_next = req_len;
               fail_next = 1'b0; to_next = 1'b0; perr_next = 1'b0;
               acnt_next = 3'h0; cnt_next = 12'h0; ph_next = 2'h0;
               st_next = ST_CMD1;
               if (req_op == nos_pkg::NOS_OP_PROG) begin
                  // Fifth program of one page, or a page below the last in the same block, is refused
                  perr_next = (req_addr[27:12] == last_page_reg[27:12] &&
                               nop_reg >= 3'(nos_pkg::PARTIAL_PROG_MAX)) ||
                              (req_addr[27:18] == last_page_reg[27:18] &&
                               req_addr[17:12] < last_page_reg[17:12]);
                  if (perr_next) begin
                     done_next = 1'b1;
                     st_next   = ST_IDLE;
                  end else if (req_addr[27:12] == last_page_reg[27:12]) begin
                     nop_next = nop_reg + 3'h1;
                  end else begin
                     nop_next = 3'h1;
                     last_page_next = req_addr;
                  end
               end else if (req_op == nos_pkg::NOS_OP_ERASE &&
                            req_addr[27:18] == last_page_reg[27:18]) begin
                  nop_next = 3'h0;
                  last_page_next = 28'hfffffff;
               end
            end
         end
         ST_CMD1, ST_CMD2, ST_STCMD, ST_ADDR, ST_DATA, ST_STRD, ST_RDDAT: begin
            if (st_reg == ST_DATA && ph_reg == 2'h0 && !wr_valid) ph_next = 2'h0;
            else if (st_reg == ST_RDDAT && ph_reg == 2'h0 && !rbuf.in_ready) ph_next = 2'h0;
            else ph_next = ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
               case (st_reg)
                  ST_CMD1: case (op_reg)
                     nos_pkg::NOS_OP_READ:  dout_next = nos_pkg::CMD_READ_SETUP;
                     nos_pkg::NOS_OP_PROG:  dout_next = nos_pkg::CMD_PROG_SETUP;
                     nos_pkg::NOS_OP_ERASE: dout_next = nos_pkg::CMD_ERASE_SETUP;
                     default:               dout_next = nos_pkg::CMD_RESET;
                  endcase
                  ST_CMD2:  dout_next = is_erase ? nos_pkg::CMD_ERASE_CONFIRM :
                            (op_reg == nos_pkg::NOS_OP_PROG) ? nos_pkg::CMD_PROG_CONFIRM :
                            nos_pkg::CMD_READ_CONFIRM;
                  ST_STCMD: dout_next = nos_pkg::CMD_STATUS;
                  ST_ADDR:  dout_next = addr_byte(addr_reg, acnt_reg, is_erase);
                  ST_DATA:  dout_next = wr_data;
                  default:  dout_next = dout_reg;
               endcase
            end
            if (ph_reg == 2'h3) begin
               tmr_next = 32'h0;
               case (st_reg)
                  ST_CMD1: st_next = (op_reg == nos_pkg::NOS_OP_RESET) ? ST_WAIT : ST_ADDR;
                  ST_ADDR: begin
                     acnt_next = acnt_reg + 3'h1;
                     if (acnt_reg == 3'(is_erase ? nos_pkg::ADDR_CYCLES_ROW - 1 :
                                                   nos_pkg::ADDR_CYCLES_FULL - 1))
                        st_next = (op_reg == nos_pkg::NOS_OP_PROG) ? ST_DATA : ST_CMD2;
                  end
                  ST_DATA, ST_RDDAT: begin
                     cnt_next = cnt_reg + 12'h1;
                     if (cnt_reg + 12'h1 >= len_reg)
                        st_next = (st_reg == ST_DATA) ? ST_CMD2 : ST_DONE;
                  end
                  ST_CMD2:  st_next = ST_WAIT;
                  ST_STCMD: st_next = ST_STRD;
                  ST_STRD: begin
                     fail_next = io_s2_reg[nos_pkg::STATUS_FAIL_BIT];
                     st_next = ST_DONE;
                  end
                  default: st_next = st_reg;
               endcase
            end
         end
         ST_WAIT: begin
            // Skip the first cycles while ready_busy_n has not yet dropped
            if (tmr_reg > 32'(nos_pkg::BUSY_SETTLE_CYCLES + 2) && rb_s2_reg) begin
               ph_next = 2'h0; cnt_next = 12'h0;
               case (op_reg)
                  nos_pkg::NOS_OP_READ:  st_next = ST_RDDAT;
                  nos_pkg::NOS_OP_RESET: st_next = ST_DONE;
                  default:               st_next = ST_STCMD;
               endcase
            end else if (tmr_reg > op_limit(op_reg)) begin
               to_next = 1'b1;
               op_next = nos_pkg::NOS_OP_RESET;
               st_next = ST_CMD1;
            end
         end
         ST_DONE: begin
            done_next = 1'b1;
            st_next = ST_IDLE;
         end
         default: st_next = ST_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= ST_POWER; ph_reg <= 2'h0; op_reg <= 2'h0; addr_reg <= 28'h0;
         cnt_reg <= 12'h0; len_reg <= 12'h0; acnt_reg <= 3'h0; tmr_reg <= 32'h0;
         dout_reg <= 8'h00; nop_reg <= 3'h0; last_page_reg <= 28'hfffffff;
         fail_reg <= 1'b0; to_reg <= 1'b0; done_reg <= 1'b0; perr_reg <= 1'b0;
         wg_reg <= 1'b0;
      end else begin
         st_reg <= st_next; ph_reg <= ph_next; op_reg <= op_next; addr_reg <= addr_next;
         cnt_reg <= cnt_next; len_reg <= len_next; acnt_reg <= acnt_next;
         tmr_reg <= tmr_next; dout_reg <= dout_next; nop_reg <= nop_next;
         last_page_reg <= last_page_next; fail_reg <= fail_next; to_reg <= to_next;
         done_reg <= done_next; perr_reg <= perr_next; wg_reg <= wg_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   logic wr_cycle, rd_cycle;
   assign wr_cycle = (st_reg == ST_CMD1) || (st_reg == ST_CMD2) || (st_reg == ST_STCMD) ||
                     (st_reg == ST_ADDR) || (st_reg == ST_DATA);
   assign rd_cycle = (st_reg == ST_STRD) || (st_reg == ST_RDDAT);
   // Latch strobes qualify the cycle type
   assign command_latch_strobe = (st_reg == ST_CMD1) || (st_reg == ST_CMD2) ||
                                 (st_reg == ST_STCMD);
   assign address_latch_strobe = (st_reg == ST_ADDR);
   assign chip_select_n   = !(wr_cycle || rd_cycle || st_reg == ST_WAIT);
   assign write_strobe_n  = !(wr_cycle && ph_reg == 2'h1);
   assign output_strobe_n = !(rd_cycle && (ph_reg == 2'h1 || ph_reg == 2'h2));
   assign write_guard_n   = wg_reg;
   assign io_out          = dout_reg;
   assign io_oe_n         = !wr_cycle;
   assign done            = done_reg;
   assign fail            = fail_reg;
   assign timeout         = to_reg;
   assign part_limit_err  = perr_reg;
   assign powered_up      = (st_reg != ST_POWER);
endmodule // nos_host_ctrl

// *** core/nos_pkg.sv ***
// Package: constants for the NAND operation sequencer host controller.
// Assumes a 100 MHz core clock and an 8-bit multiplexed NAND device on the pins.
package nos_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS              = 10;
   localparam int POWER_UP_WAIT_US           = 100;
   localparam int CELL_TO_REGISTER_TIME_US   = 25;
   localparam int PROGRAM_TIME_MAX_US        = 700;
   localparam int BLOCK_ERASE_TIME_MAX_MS    = 3;
   localparam int RESET_BUSY_MAX_US          = 500;
   localparam int WE_HIGH_TO_BUSY_NS         = 100;
   localparam int POWER_UP_CYCLES            = (POWER_UP_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
   localparam int READ_TIMEOUT_CYCLES        = CELL_TO_REGISTER_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int PROGRAM_TIMEOUT_CYCLES     = PROGRAM_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int ERASE_TIMEOUT_CYCLES       = BLOCK_ERASE_TIME_MAX_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RESET_TIMEOUT_CYCLES       = RESET_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int BUSY_SETTLE_CYCLES         = (WE_HIGH_TO_BUSY_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Commands and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP    = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM  = 8'h30;
   localparam logic [7:0] CMD_PROG_SETUP    = 8'h80;
   localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_STATUS        = 8'h70;
   localparam logic [7:0] CMD_RESET         = 8'hff;
   localparam logic [7:0] ERASED_BYTE       = 8'hff;
   localparam int         STATUS_FAIL_BIT   = 0;
   localparam int         STATUS_READY_BIT  = 6;
   localparam int         ADDR_CYCLES_FULL  = 4;
   localparam int         ADDR_CYCLES_ROW   = 2;
   localparam int         PAGE_BYTES        = 2112;
   localparam int         PARTIAL_PROG_MAX  = 4;

   // Operation codes on the user request port
   typedef enum logic [1:0] {
      NOS_OP_READ  = 2'h0,
      NOS_OP_PROG  = 2'h1,
      NOS_OP_ERASE = 2'h2,
      NOS_OP_RESET = 2'h3
   } nos_op_t;

endpackage

// *** core/nos_skid_buf.sv ***
// Module: two-entry buffer with valid/ready on both sides.
// Assumes one clock and the asynchronous active-low reset nrst.
`timescale 1ns/1ps
module nos_skid_buf #(
   parameter int WIDTH = 8
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   nos_buf_if.buf_side bus
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem_reg [2];
   logic [WIDTH-1:0] mem_next [2];
   logic             wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0]       cnt_reg, cnt_next;

   initial begin
      if (WIDTH < 1) $error("nos_skid_buf: WIDTH must be positive");
   end

   assign bus.in_ready  = (cnt_reg != 2'h2);
   assign bus.out_valid = (cnt_reg != 2'h0);
   assign bus.out_data  = mem_reg[rp_reg];

   // Pointer and count update
   always_comb begin
      logic push, pop;
      push = bus.in_valid && bus.in_ready;
      pop  = bus.out_valid && bus.out_ready;
      mem_next[0] = mem_reg[0];
      mem_next[1] = mem_reg[1];
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wp_reg] = bus.in_data;
         wp_next = ~wp_reg;
      end
      if (pop) rp_next = ~rp_reg;
      if (push && !pop) cnt_next = cnt_reg + 2'h1;
      else if (pop && !push) cnt_next = cnt_reg - 2'h1;
   end

   // Registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         mem_reg[0] <= mem_next[0];
         mem_reg[1] <= mem_next[1];
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule // nos_skid_buf

// *** verif/nos_flash_model.sv ***
// Behavioural 8-bit NAND device on the host controller pins.
// Assumes ns time units; busy times are short stand-ins for the real ones.
`timescale 1ns/1ps
module nos_flash_model (
   input  wire logic       command_latch_strobe,
   input  wire logic       address_latch_strobe,
   input  wire logic       chip_select_n,
   input  wire logic       write_strobe_n,
   input  wire logic       output_strobe_n,
   input  wire logic       write_guard_n,
   input  wire logic [7:0] io_out,
   input  wire logic       io_oe_n,
   input  wire logic       fail_next,
   input  wire logic       hang,
   output logic            ready_busy_n,
   output logic [7:0]      io_in
);
   logic [7:0] mem [64];
   logic [7:0] dv;
   logic [5:0] col;
   logic       st_mode, fail_st;
   int         acnt;
   time        until_t;

   // Shipped state is all ones
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      until_t = 0; acnt = 0; st_mode = 0; fail_st = 0; dv = 8'h00; col = 6'h00;
   end

   // Busy line low until the deadline passes
   always #1 ready_busy_n = ($time >= until_t);

   // Latch command, address or data on the write strobe rise
   always @(posedge write_strobe_n) if (!chip_select_n) begin
      if (command_latch_strobe && !address_latch_strobe && output_strobe_n) begin
         acnt = 0;
         st_mode = (io_out == 8'h70);
         case (io_out)
            8'h30: until_t = $time + (hang ? 1000000000 : 1000);
            8'h10: if (write_guard_n) begin
               until_t = $time + 2000;
               fail_st = fail_next;
            end
            8'hd0: if (write_guard_n) begin
               until_t = $time + 3000;
               foreach (mem[i]) mem[i] = 8'hff;
               fail_st = fail_next;
            end
            8'hff: until_t = $time + 500;
            default: ;
         endcase
      end else if (address_latch_strobe && !command_latch_strobe) begin
         if (acnt == 0) col = io_out[5:0];
         acnt++;
      end else begin
         mem[col] = io_out;
         col++;
      end
   end

   // Status or data on the output strobe fall
   always @(negedge output_strobe_n) if (!chip_select_n) begin
      dv = st_mode ? {write_guard_n, ready_busy_n, 5'h00, fail_st} : mem[col];
      if (!st_mode) col++;
   end

   // Undriven bus shows the inverse of the last value
   assign io_in = !io_oe_n ? io_out : (!output_strobe_n && !chip_select_n) ? dv : ~dv;
endmodule // nos_flash_model

// *** verif/nos_host_ctrl_chk.sv ***
// Checker on the host controller pins and power-up outputs.
// Assumes one clock core_clk and the active-low reset nrst.
`timescale 1ns/1ps
module nos_host_ctrl_chk #(
   parameter int POWER_UP_CYC = 50
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic powered_up,
   input wire logic write_guard_n,
   input wire logic command_latch_strobe,
   input wire logic address_latch_strobe,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_strobe_n,
   input wire logic io_oe_n
);
   int up_cnt_reg, up_cnt_next;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Cycles since reset release, saturating
   always_comb up_cnt_next = (up_cnt_reg < POWER_UP_CYC) ? up_cnt_reg + 1 : up_cnt_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) up_cnt_reg <= 0;
      else up_cnt_reg <= up_cnt_next;
   end

   sequence wr_fall; $fell(write_strobe_n); endsequence
   sequence rd_fall; $fell(output_strobe_n); endsequence

   latch_excl_a: assert property (!(command_latch_strobe && address_latch_strobe))
      else $error("both latch strobes high");
   cycle_qual_a: assert property (
      !write_strobe_n |-> !chip_select_n && output_strobe_n && !io_oe_n)
      else $error("write cycle badly qualified");
   wr_pulse_a: assert property (wr_fall |=> write_strobe_n)
      else $error("write strobe not one cycle");
   rd_pulse_a: assert property (
      rd_fall |-> io_oe_n ##1 (!output_strobe_n && io_oe_n) ##1 output_strobe_n)
      else $error("read strobe shape wrong");
   guard_low_a: assert property (!powered_up |-> !write_guard_n)
      else $error("write guard high in power-up");
   guard_high_a: assert property (powered_up |-> write_guard_n)
      else $error("write guard low after power-up");
   quiet_early_a: assert property (!powered_up |-> chip_select_n && write_strobe_n)
      else $error("bus active in power-up");
   wait_len_a: assert property ($rose(powered_up) |-> up_cnt_reg >= POWER_UP_CYC)
      else $error("power-up wait too short");
endmodule // nos_host_ctrl_chk

bind nos_host_ctrl nos_host_ctrl_chk #(.POWER_UP_CYC(POWER_UP_CYC)) i_chk (.core_clk, .nrst,
   .powered_up, .write_guard_n, .command_latch_strobe, .address_latch_strobe, .chip_select_n,
   .write_strobe_n, .output_strobe_n, .io_oe_n);

// *** verif/testbench.sv ***
// Self-checking bench for the NAND host controller.
// Assumes the device model on the pins and shortened busy limits.
`timescale 1ns/1ps
module testbench;
   logic        core_clk = 0, nrst = 0, req_valid = 0, wr_valid = 0, rd_ready = 0;
   logic        fail_next = 0, hang = 0, qa, wa, ra, dn;
   logic [1:0]  req_op = 2'h0;
   logic [27:0] req_addr = 28'h0000000;
   logic [11:0] req_len = 12'h001;
   logic [7:0]  wr_data = 8'h00, rdd, io_in, io_out, rd_data;
   logic        req_ready, wr_ready, rd_valid, done, fail, timeout, part_limit_err;
   logic        powered_up, command_latch_strobe, address_latch_strobe, chip_select_n;
   logic        write_strobe_n, output_strobe_n, write_guard_n, ready_busy_n, io_oe_n;
   logic [7:0]  wq [$], rq [$];
   logic [3:0]  cyc = 4'h0;
   int          n_mismatch = 0, checks = 0;

   always #5 core_clk = ~core_clk;

   nos_host_ctrl #(.POWER_UP_CYC(50), .READ_TO_CYC(300), .PROG_TO_CYC(400),
      .ERASE_TO_CYC(500), .RESET_TO_CYC(300)) i_dut (.core_clk, .nrst, .req_valid,
      .req_ready, .req_op, .req_addr, .req_len, .wr_valid, .wr_ready, .wr_data, .rd_valid,
      .rd_ready, .rd_data, .done, .fail, .timeout, .part_limit_err, .powered_up,
      .command_latch_strobe, .address_latch_strobe, .chip_select_n, .write_strobe_n,
      .output_strobe_n, .write_guard_n, .ready_busy_n, .io_in, .io_out, .io_oe_n);
   nos_flash_model i_mem (.command_latch_strobe, .address_latch_strobe, .chip_select_n,
      .write_strobe_n, .output_strobe_n, .write_guard_n, .io_out, .io_oe_n, .fail_next,
      .hang, .ready_busy_n, .io_in);

   // Handshakes taken at the edge, seen settled half a cycle before
   always @(negedge core_clk) begin
      qa = req_valid && req_ready;
      wa = wr_valid && wr_ready;
      ra = rd_valid && rd_ready;
      rdd = rd_data;
      if (done === 1'b1) dn = 1'b1;
   end
   // Write feeder and slow read drain
   always @(posedge core_clk) begin
      #1;
      if (ra) rq.push_back(rdd);
      if (wa) wq.delete(0);
      wr_valid = (wq.size() > 0);
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
      cyc = cyc + 4'h1;
      rd_ready = (cyc == 4'h0);
   end

   task automatic final_report;
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic lost;
      n_mismatch++;
      final_report;
   endtask

   // One request to completion, then its result flags
   task automatic run_op(input logic [1:0] op, input logic [11:0] n, input logic ef, et, ep);
      int i;
      rq.delete();
      dn = 1'b0;
      req_op = op; req_len = n; req_valid = 1'b1;
      for (i = 0; i < 5000 && !dn; i++) begin
         @(posedge core_clk); #1;
         if (qa) req_valid = 1'b0;
      end
      if (!dn) lost;
      for (i = 0; i < 200 && op == 2'h0 && rq.size() < n; i++) begin
         @(posedge core_clk); #1;
      end
      chk(fail, ef);
      chk(timeout, et);
      chk(part_limit_err, ep);
   endtask
   task automatic read_chk(input logic [7:0] e0, e1, e2, e3);
      run_op(2'h0, 12'h004, 1'b0, 1'b0, 1'b0);
      chk(8'(rq.size()), 8'h04);
      if (rq.size() == 4) begin
         chk(rq[0], e0); chk(rq[1], e1); chk(rq[2], e2); chk(rq[3], e3);
      end
   endtask

   task automatic t_power;
      int i;
      chk(write_guard_n, 1'b0);
      chk(req_ready, 1'b0);
      for (i = 0; i < 200 && powered_up !== 1'b1; i++) @(posedge core_clk);
      if (i == 200) lost;
      #1 chk(write_guard_n, 1'b1);
   endtask
   task automatic t_prog_read;
      run_op(2'h2, 12'h001, 1'b0, 1'b0, 1'b0);
      read_chk(8'hff, 8'hff, 8'hff, 8'hff);
      wq = '{8'h11, 8'h22, 8'h33, 8'h44};
      run_op(2'h1, 12'h004, 1'b0, 1'b0, 1'b0);
      read_chk(8'h11, 8'h22, 8'h33, 8'h44);
   endtask
   task automatic t_fail;
      fail_next = 1'b1;
      wq = '{8'h5a};
      run_op(2'h1, 12'h001, 1'b1, 1'b0, 1'b0);
      fail_next = 1'b0;
   endtask
   task automatic t_part;
      int k;
      run_op(2'h2, 12'h001, 1'b0, 1'b0, 1'b0);
      for (k = 1; k <= 5; k++) begin
         wq = '{8'h0f};
         run_op(2'h1, 12'h001, 1'b0, 1'b0, k == 5);
      end
      // A higher page of the block is taken, a lower one then refused
      req_addr = 28'h0002000;
      wq = '{8'h3c};
      run_op(2'h1, 12'h001, 1'b0, 1'b0, 1'b0);
      req_addr = 28'h0001000;
      run_op(2'h1, 12'h001, 1'b0, 1'b0, 1'b1);
      req_addr = 28'h0000000;
      wq.delete();
   endtask
   task automatic t_reset;
      run_op(2'h3, 12'h001, 1'b0, 1'b0, 1'b0);
      chk(ready_busy_n, 1'b1);
   endtask
   task automatic t_timeout;
      hang = 1'b1;
      run_op(2'h0, 12'h001, 1'b0, 1'b1, 1'b0);
      hang = 1'b0;
      chk(ready_busy_n, 1'b1);
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      #1 nrst = 1'b1;
      t_power;
      t_prog_read;
      t_fail;
      t_part;
      t_reset;
      t_timeout;
      final_report;
   end
endmodule // testbench
